/* File: fpal_pkg.sv */
// constants, opcodes and state encodings for the flash access lock
// shared by the design module and the bench; no clocks or processes here
package fpal_pkg;
    localparam int CLK_MHZ = 25;
    localparam int VERIFY_US = 10;
    localparam int VERIFY_CYC = VERIFY_US * CLK_MHZ;
    localparam int SCAN_MS = 10;
    localparam int SCAN_CYC_DEF = SCAN_MS * 1000 * CLK_MHZ;
    localparam int SEC_CYC_DEF = 1000000 * CLK_MHZ;
    localparam int SETTLE_CYC = 4;
    localparam int AW = 16;
    localparam int FRAME_BITS = 32;
    localparam logic [2:0] PAD_WAIT_SEC = 3'h6;
    localparam logic [2:0] MAX_WAIT_SEC = 3'h6;
    localparam logic [3:0] KEY_LEN = 4'h8;
    localparam logic [15:0] KEY_BASE = 16'hfff8;
    localparam logic [15:0] BOOT_LO = 16'hf000;
    localparam logic [15:0] BOOT_HI = 16'hfff8;
    localparam logic [7:0] INFO_CAL_LO = 8'h20;
    localparam logic [7:0] INFO_CAL_SUM = 8'h39;
    localparam logic [7:0] INFO_WAIT = 8'h40;
    localparam logic [7:0] ERASED = 8'hff;
    localparam logic [7:0] RSP_FAIL = 8'h00;
    localparam logic [7:0] RSP_PASS = 8'h01;
    localparam logic [7:0] RSP_REJECT = 8'hee;
    localparam int WAIT_PAD_ONE_BIT = 6;
    localparam int WAIT_PAD_TWO_BIT = 7;

    typedef enum logic [7:0] {
        OP_ERASE_MAIN = 8'h01,
        OP_ERASE_ALL = 8'h02,
        OP_VERIFY = 8'h03,
        OP_WR_MAIN = 8'h04,
        OP_RD_INFO = 8'h05,
        OP_WR_INFO = 8'h06,
        OP_FAST_WR = 8'h07,
        OP_FAST_RD = 8'h08,
        OP_ERASE_NOBOOT = 8'h09,
        OP_ERASE_SECTOR = 8'h0a,
        OP_SET_ADDR = 8'h0b,
        OP_UNLOCK = 8'h0c
    } fpal_op_t;

    typedef enum logic [2:0] {
        EX_IDLE = 3'b001,
        EX_ERASE = 3'b010,
        EX_DELAY = 3'b100
    } fpal_ex_t;

    typedef enum logic [4:0] {
        BT_LOAD = 5'b00001,
        BT_SCAN = 5'b00010,
        BT_WAIT = 5'b00100,
        BT_HOST = 5'b01000,
        BT_USER = 5'b10000
    } fpal_boot_t;
endpackage

/* File: fpal_flash_access.sv */
// flash programming access lock: programmer serial link, boot wait timing,
// in-system command port, key lock, one-time info rules, erase engine.
// assumes prog_clock_pin is the programmer's clock, idle outside frames.
// Function
// R1: info 0x39 equals xor of calibration bytes
// R2: programmer writes reserved info bytes as zero
// R3: wait seconds from low four control bits
// R4: checked i2c pad low forces six seconds
// R5: wait time stays within zero to six
// R6: user info bytes writable once after erase
// R7: manufacturer bytes writable only erased programmer mode
// R8: locked programmer accepts only erases and verify
// R9: eight key bytes at top unlock
// R10: each read-verify attempt lasts ten microseconds
// R11: erased flash verifies against all ones
// R12: programmer mode offers eight commands
// R13: programmer enters mode holding reset high
// R14: link pins: clock, data in, enable, busy, out
// R15: boot region protected, boot runs before user; code lets in-system sector erase clear boot sectors
// R16: boot scans request ports about ten milliseconds
// R17: no host command in wait: go user
// R18: boot code offers the in-system command set
// R19: in-system path locked until key verify
// R20: wait setting read from info byte 0x40
// R21: busy held from acceptance until done
// R22: data in on rise, out on fall
`timescale 1ns/100ps
module fpal_flash_access
    import fpal_pkg::*;
#(
    parameter int SCAN_CYC = SCAN_CYC_DEF,
    parameter int SEC_CYC = SEC_CYC_DEF,
    parameter int SECT_W = 9
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic prog_clock_pin,
    input wire logic test_enable_n,
    input wire logic data_in_pin,
    output logic data_out_pin,
    output logic busy_pin,
    input wire logic programmer_mode,
    input wire logic i2c_clock_pad_one,
    input wire logic i2c_clock_pad_two,
    input wire logic isp_request,
    input wire logic host_mode_request,
    input wire logic isp_cmd_valid,
    input wire logic [7:0] isp_cmd,
    input wire logic [15:0] isp_addr,
    input wire logic [7:0] isp_data,
    output logic isp_cmd_ready,
    output logic isp_rsp_valid,
    output logic [7:0] isp_rsp_data,
    output logic boot_active,
    output logic isp_active,
    output logic user_code_run,
    output logic prog_unlocked,
    output logic isp_unlocked,
    output logic cal_checksum_ok,
    output logic [2:0] wait_sec
);
    logic [7:0] mem [2**AW];
    logic [7:0] info [256];

    // link domain
    logic link_clr;
    logic [4:0] bit_cnt;
    logic [31:0] rx_sh;
    logic [31:0] rx_word;
    logic req_tgl;

    assign link_clr = !arst_n || test_enable_n;

    always_ff @(posedge prog_clock_pin or posedge link_clr) begin
        if (link_clr) begin
            bit_cnt <= '0;
            rx_sh <= '0;
        end else begin
            bit_cnt <= bit_cnt + 5'h01; // R22
            rx_sh <= {rx_sh[30:0], data_in_pin}; // R22
        end
    end

    // rx_word stays still until the next frame, guarded by busy
    always_ff @(posedge prog_clock_pin or negedge arst_n) begin
        if (!arst_n) begin
            rx_word <= '0;
            req_tgl <= 1'b0;
        end else if (!test_enable_n && bit_cnt == 5'(FRAME_BITS - 1)) begin
            rx_word <= {rx_sh[30:0], data_in_pin}; // R14
            req_tgl <= !req_tgl;
        end
    end

    // reply byte shifted msb first on falling edges of the next frame
    always_ff @(negedge prog_clock_pin or negedge arst_n) begin
        if (!arst_n) begin
            data_out_pin <= 1'b0;
        end else if (!test_enable_n && bit_cnt != 5'h00 && bit_cnt <= 5'h08) begin
            data_out_pin <= isp_rsp_data[3'(5'h08 - bit_cnt)]; // R22
        end else begin
            data_out_pin <= 1'b0;
        end
    end

    // three-stage synchronisers, value taken when stages two and three agree
    logic [3:0] raw_in;
    logic [2:0] sy [4];
    logic [3:0] sv;
    assign raw_in = {i2c_clock_pad_two, i2c_clock_pad_one, programmer_mode, req_tgl};

    for (genvar i = 0; i < 4; i++) begin : g_sync
        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                sy[i] <= '0;
                sv[i] <= 1'b0;
            end else begin
                sy[i] <= {sy[i][1:0], raw_in[i]};
                if (sy[i][2] == sy[i][1]) begin
                    sv[i] <= sy[i][2];
                end
            end
        end
    end

    logic req_seen;
    logic prog_evt;
    assign prog_evt = sv[0] != req_seen;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            req_seen <= 1'b0;
        end else begin
            req_seen <= sv[0];
        end
    end

    // command decode
    fpal_ex_t ex_st;
    fpal_boot_t boot_st;
    logic in_prog, in_isp, start, unl, ok, boot_hit, info_ok, key_hit, src_isp;
    fpal_op_t op;
    logic [15:0] addr, ea, ptr, er_addr, er_sect_base;
    logic [7:0] data, rsp;
    logic [3:0] key_cnt;
    logic mass_erased, er_info, er_noboot, er_sect, er_last;
    logic mwe, iwe;
    logic [15:0] maddr;
    logic [7:0] mwd, iaddr, iwd;

    always_comb begin
        in_prog = prog_evt && sv[1] && ex_st == EX_IDLE;
        in_isp = isp_cmd_valid && isp_cmd_ready && !in_prog;
        start = in_prog || in_isp;
        op = in_prog ? fpal_op_t'(rx_word[31:24]) : fpal_op_t'(isp_cmd);
        addr = in_prog ? rx_word[23:8] : isp_addr;
        data = in_prog ? rx_word[7:0] : isp_data;
        ea = (op == OP_FAST_WR || op == OP_FAST_RD) ? ptr : addr;
        unl = in_prog ? prog_unlocked : isp_unlocked;
        boot_hit = ea >= BOOT_LO && ea < BOOT_HI;
        key_hit = ea == KEY_BASE + 16'(key_cnt) && mem[ea] == data; // R9 R11
        if (ea[7:0] > INFO_WAIT) begin
            info_ok = info[ea[7:0]] == ERASED; // R6
        end else if (ea[7:0] == INFO_WAIT) begin
            info_ok = info[ea[7:0]] == ERASED || (in_prog && mass_erased);
        end else begin
            info_ok = in_prog && mass_erased; // R7
        end
        case (op)
            OP_ERASE_MAIN, OP_ERASE_ALL: ok = in_prog; // R8 R12
            OP_VERIFY: ok = 1'b1; // R8 R19
            OP_UNLOCK: ok = in_isp; // R18
            OP_WR_MAIN, OP_FAST_WR: ok = unl && (in_prog || !boot_hit); // R15
            OP_RD_INFO, OP_FAST_RD: ok = unl;
            OP_WR_INFO: ok = unl && info_ok && ea[15:8] == 8'h00;
            OP_ERASE_NOBOOT, OP_ERASE_SECTOR, OP_SET_ADDR: ok = in_isp && unl; // R18 R19
            default: ok = 1'b0;
        endcase
        case (op)
            OP_VERIFY: rsp = key_hit ? RSP_PASS : RSP_FAIL;
            OP_RD_INFO: rsp = info[ea[7:0]];
            OP_FAST_RD: rsp = mem[ea];
            default: rsp = RSP_PASS;
        endcase
        if (!ok) begin
            rsp = RSP_REJECT;
        end
        er_last = er_sect ? &er_addr[SECT_W-1:0] : &er_addr;
        mwe = 1'b0;
        maddr = ea;
        mwd = data;
        iwe = 1'b0;
        iaddr = ea[7:0];
        iwd = data;
        if (ex_st == EX_ERASE) begin
            mwe = !(er_noboot && er_addr >= BOOT_LO && er_addr < BOOT_HI); // R15
            maddr = er_addr;
            mwd = ERASED;
            iwe = er_info && er_addr[15:8] == 8'h00;
            iaddr = er_addr[7:0];
            iwd = ERASED;
        end else if (start && ok) begin
            mwe = op == OP_WR_MAIN || op == OP_FAST_WR;
            iwe = op == OP_WR_INFO; // R6 R7
        end
    end

    always_ff @(posedge clk) begin
        if (mwe) begin
            mem[maddr] <= mwd;
        end
        if (iwe) begin
            info[iaddr] <= iwd;
        end
    end

    // command engine
    logic [7:0] dly;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ex_st <= EX_IDLE;
            busy_pin <= 1'b0;
            isp_rsp_data <= '0;
            isp_rsp_valid <= 1'b0;
            src_isp <= 1'b0;
            dly <= '0;
        end else begin
            isp_rsp_valid <= 1'b0;
            case (ex_st)
                EX_IDLE: begin
                    if (start) begin
                        busy_pin <= 1'b1; // R21
                        isp_rsp_data <= rsp;
                        src_isp <= in_isp;
                        dly <= (ok && op == OP_VERIFY) ? 8'(VERIFY_CYC - 1) : 8'h00; // R10
                        ex_st <= (ok && (op == OP_ERASE_MAIN || op == OP_ERASE_ALL
                            || op == OP_ERASE_NOBOOT || op == OP_ERASE_SECTOR))
                            ? EX_ERASE : EX_DELAY;
                    end
                end
                EX_ERASE: begin
                    if (er_last) begin
                        ex_st <= EX_IDLE;
                        busy_pin <= 1'b0; // R21
                        isp_rsp_valid <= src_isp;
                    end
                end
                EX_DELAY: begin
                    dly <= dly - 8'h01;
                    if (dly == 8'h00) begin
                        ex_st <= EX_IDLE;
                        busy_pin <= 1'b0; // R21
                        isp_rsp_valid <= src_isp;
                    end
                end
                default: ex_st <= EX_IDLE;
            endcase
        end
    end

    // erase sweep
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            er_addr <= '0;
            er_info <= 1'b0;
            er_noboot <= 1'b0;
            er_sect <= 1'b0;
            er_sect_base <= '0;
            mass_erased <= 1'b0;
        end else if (ex_st == EX_IDLE && start && ok) begin
            er_info <= op == OP_ERASE_ALL;
            er_noboot <= op == OP_ERASE_NOBOOT;
            er_sect <= op == OP_ERASE_SECTOR;
            er_sect_base <= {addr[15:SECT_W], SECT_W'(0)};
            er_addr <= op == OP_ERASE_SECTOR ? {addr[15:SECT_W], SECT_W'(0)} : 16'h0000;
            if (op == OP_WR_MAIN || op == OP_FAST_WR) begin
                mass_erased <= 1'b0;
            end
        end else if (ex_st == EX_ERASE) begin
            er_addr <= er_addr + 16'h0001;
            if (er_last && er_info) begin
                mass_erased <= 1'b1; // R7
            end
        end
    end

    // key progress, locks and address pointer
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            key_cnt <= '0;
            prog_unlocked <= 1'b0; // R8
            isp_unlocked <= 1'b0; // R19
            ptr <= '0;
        end else if (start && ok) begin
            if (op == OP_VERIFY) begin
                key_cnt <= key_hit && key_cnt != KEY_LEN - 4'h1 ? key_cnt + 4'h1 : 4'h0;
                if (key_hit && key_cnt == KEY_LEN - 4'h1) begin
                    prog_unlocked <= prog_unlocked || in_prog; // R9
                    isp_unlocked <= isp_unlocked || in_isp; // R19
                end
                ptr <= ea + 16'h0001;
            end else if (op == OP_UNLOCK) begin
                key_cnt <= '0;
            end else if (op == OP_SET_ADDR) begin
                ptr <= addr;
            end else if (op == OP_WR_MAIN || op == OP_FAST_WR || op == OP_FAST_RD) begin
                ptr <= ea + 16'h0001;
            end
        end else if (boot_st == BT_USER) begin
            isp_unlocked <= 1'b0; // R17
        end
    end

    // boot sequence
    logic [31:0] bcnt;
    logic seen_req;
    logic [2:0] next_wait;
    logic [7:0] wbyte;

    always_comb begin
        wbyte = info[INFO_WAIT]; // R20
        next_wait = 3'(wbyte[0]) + 3'(wbyte[1]) + {1'b0, wbyte[2], 1'b0}
            + {1'b0, wbyte[3], 1'b0}; // R3
        if ((wbyte[WAIT_PAD_TWO_BIT] && !sv[3]) || (wbyte[WAIT_PAD_ONE_BIT] && !sv[2])) begin
            next_wait = PAD_WAIT_SEC; // R4
        end else if (next_wait > MAX_WAIT_SEC) begin
            next_wait = MAX_WAIT_SEC; // R5
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            boot_st <= BT_LOAD;
            bcnt <= 32'(SETTLE_CYC);
            seen_req <= 1'b0;
            wait_sec <= '0;
            boot_active <= 1'b0;
        end else begin
            boot_active <= boot_st != BT_USER; // R15
            case (boot_st)
                BT_LOAD: begin
                    bcnt <= bcnt - 32'h1;
                    if (bcnt == 32'h0) begin
                        wait_sec <= next_wait; // R3 R4 R5
                        bcnt <= 32'(SCAN_CYC - 1);
                        boot_st <= BT_SCAN;
                    end
                end
                BT_SCAN: begin
                    bcnt <= bcnt - 32'h1;
                    seen_req <= seen_req || isp_request; // R16
                    if (bcnt == 32'h0) begin
                        bcnt <= 32'(wait_sec) * 32'(SEC_CYC);
                        boot_st <= (seen_req || isp_request) ? BT_WAIT : BT_USER;
                    end
                end
                BT_WAIT: begin
                    bcnt <= bcnt - 32'h1;
                    if (host_mode_request) begin
                        boot_st <= BT_HOST; // R17
                    end else if (bcnt == 32'h0) begin
                        boot_st <= BT_USER; // R17
                    end
                end
                BT_HOST, BT_USER: boot_st <= boot_st;
                default: boot_st <= BT_LOAD;
            endcase
        end
    end

    assign isp_active = boot_st[3];
    assign user_code_run = boot_st[4];

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            isp_cmd_ready <= 1'b0;
        end else begin
            isp_cmd_ready <= ex_st == EX_IDLE && !start && boot_st == BT_HOST && !sv[1];
        end
    end

    // calibration checksum over 0x20..0x38
    logic [7:0] cal_xor;
    always_comb begin
        cal_xor = '0;
        for (int k = INFO_CAL_LO; k < INFO_CAL_SUM; k++) begin
            cal_xor = cal_xor ^ info[k];
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cal_checksum_ok <= 1'b0;
        end else begin
            cal_checksum_ok <= cal_xor == info[INFO_CAL_SUM]; // R1
        end
    end

    chk_locked_reject: assert property (@(posedge clk) disable iff (!arst_n) // R8
        in_prog && !prog_unlocked && op == OP_WR_MAIN |=> isp_rsp_data == RSP_REJECT)
        else $error("locked programmer write not rejected");
    chk_verify_time: assert property (@(posedge clk) disable iff (!arst_n) // R10
        start && ok && op == OP_VERIFY |-> ##250 busy_pin ##1 !busy_pin)
        else $error("verify attempt time wrong");
    chk_key_unlock: assert property (@(posedge clk) disable iff (!arst_n) // R9
        in_prog && op == OP_VERIFY && key_hit && key_cnt == 4'h7 |=> prog_unlocked)
        else $error("matching key did not unlock");
    chk_wait_range: assert property (@(posedge clk) disable iff (!arst_n) // R5
        wait_sec <= MAX_WAIT_SEC)
        else $error("wait time above six seconds");
    chk_pad_wait: assert property (@(posedge clk) disable iff (!arst_n) // R4
        boot_st == BT_LOAD && bcnt == 32'h0 && wbyte[WAIT_PAD_TWO_BIT] && !sv[3]
        |=> wait_sec == PAD_WAIT_SEC)
        else $error("low pad did not force six seconds");
    chk_user_once: assert property (@(posedge clk) disable iff (!arst_n) // R6
        iwe && ex_st == EX_IDLE && iaddr > INFO_WAIT |-> info[iaddr] == ERASED)
        else $error("user info byte written twice");
    chk_mfr_write: assert property (@(posedge clk) disable iff (!arst_n) // R7
        iwe && ex_st == EX_IDLE && iaddr < INFO_WAIT |-> in_prog && mass_erased)
        else $error("manufacturer byte written illegally");
    chk_isp_locked: assert property (@(posedge clk) disable iff (!arst_n) // R19
        in_isp && !isp_unlocked && op != OP_VERIFY && op != OP_UNLOCK
        |=> isp_rsp_data == RSP_REJECT)
        else $error("locked in-system command accepted");
    chk_boot_exit: assert property (@(posedge clk) disable iff (!arst_n) // R17
        boot_st == BT_WAIT && bcnt == 32'h0 && !host_mode_request |=> user_code_run)
        else $error("wait expiry did not start user code");
    chk_busy_hold: assert property (@(posedge clk) disable iff (!arst_n) // R21
        start |=> busy_pin)
        else $error("busy not raised on acceptance");

    cov_prog_unlock: cover property (@(posedge clk) disable iff (!arst_n)
        $rose(prog_unlocked));
    cov_host_entry: cover property (@(posedge clk) disable iff (!arst_n)
        $rose(isp_active));
    cov_erase_done: cover property (@(posedge clk) disable iff (!arst_n)
        ex_st == EX_ERASE && er_last && er_info);
endmodule

/* File: fpal_programmer.sv */
// programmer model for the flash access lock: drives link frames, reads replies
// assumes clk is the device's system clock, used only to pace busy polling
`timescale 1ns/100ps
module fpal_programmer (
    input wire logic clk,
    input wire logic data_out_pin,
    input wire logic busy_pin,
    output logic prog_clock_pin,
    output logic test_enable_n,
    output logic data_in_pin
);
    initial begin
        prog_clock_pin = 1'b0;
        test_enable_n = 1'b1;
        data_in_pin = 1'b1;
    end

    // one frame msb first at a 12 ns link period; clock stands still outside it
    task automatic send(input logic [31:0] word, output logic [7:0] reply, output logic ok);
        int n;
        reply = 8'h00;
        test_enable_n = 1'b0;
        for (n = 0; n < 32; n++) begin
            data_in_pin = word[31 - n];
            #6 prog_clock_pin = 1'b1;
            if (n >= 1 && n <= 8) begin
                reply[8 - n] = data_out_pin;
            end
            #6 prog_clock_pin = 1'b0;
        end
        #6 test_enable_n = 1'b1;
        data_in_pin = ~data_in_pin;
        // no new frame until busy has come and gone
        repeat (10) @(posedge clk);
        for (n = 0; n < 70000 && busy_pin !== 1'b0; n++) begin
            @(posedge clk);
        end
        ok = (busy_pin === 1'b0);
    endtask
endmodule

/* File: fpal_flash_access_bench.sv */
// self-checking bench for the flash access lock, programmer link and isp port
// assumes shortened scan and second counts; flash contents survive resets
`timescale 1ns/100ps
module fpal_flash_access_bench;
    import fpal_pkg::*;
    localparam int SCAN = 20;
    localparam int SEC = 10;
    localparam int LIMIT = 90000;
    typedef struct packed {logic p1; logic p2; logic [2:0] w;} fpal_row_t;
    fpal_row_t rows [4] = '{'{1'b1, 1'b1, 3'h4}, '{1'b0, 1'b1, 3'h6},
                            '{1'b1, 1'b0, 3'h6}, '{1'b0, 1'b0, 3'h6}};
    logic clk, arst_n, prog_clock_pin, test_enable_n, data_in_pin, data_out_pin, busy_pin;
    logic programmer_mode, i2c_clock_pad_one, i2c_clock_pad_two, isp_request;
    logic host_mode_request, isp_cmd_valid, isp_cmd_ready, isp_rsp_valid;
    logic [7:0] isp_cmd, isp_data, isp_rsp_data, prev;
    logic [15:0] isp_addr;
    logic boot_active, isp_active, user_code_run, prog_unlocked, isp_unlocked, cal_checksum_ok;
    logic [2:0] wait_sec;
    logic pchk;
    int fails, tests_run, cyc, bcnt, i, r;

    fpal_flash_access #(.SCAN_CYC(SCAN), .SEC_CYC(SEC), .SECT_W(9)) i_fpal_flash_access (
        .clk, .arst_n, .prog_clock_pin, .test_enable_n, .data_in_pin, .data_out_pin,
        .busy_pin, .programmer_mode, .i2c_clock_pad_one, .i2c_clock_pad_two, .isp_request,
        .host_mode_request, .isp_cmd_valid, .isp_cmd, .isp_addr, .isp_data, .isp_cmd_ready,
        .isp_rsp_valid, .isp_rsp_data, .boot_active, .isp_active, .user_code_run,
        .prog_unlocked, .isp_unlocked, .cal_checksum_ok, .wait_sec);
    fpal_programmer i_fpal_programmer (.clk, .data_out_pin, .busy_pin, .prog_clock_pin,
        .test_enable_n, .data_in_pin);

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cyc++;
        if (busy_pin === 1'b1) bcnt++;
        if (cyc == LIMIT) begin
            fails++;
            conclude();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic do_reset();
        @(negedge clk);
        arst_n = 1'b0;
        prev = 8'h00;
        pchk = 1'b1;
        repeat (2) @(negedge clk);
        check({busy_pin, isp_cmd_ready, isp_rsp_valid, boot_active, user_code_run,
               prog_unlocked, isp_unlocked, wait_sec, data_out_pin}, 16'h0000);
        arst_n = 1'b1;
    endtask

    task automatic link(input logic [7:0] op, input logic [15:0] a, input logic [7:0] d,
                        input logic [7:0] exp, input logic chk);
        logic [7:0] rep;
        logic ok;
        bcnt = 0;
        i_fpal_programmer.send({op, a, d}, rep, ok);
        check(ok, 1'b1);
        if (pchk) check(rep, prev);
        if (chk) check(isp_rsp_data, exp);
        prev = exp;
        pchk = chk;
    endtask

    task automatic in_system_programming(input logic [7:0] op, input logic [15:0] a, input logic [7:0] d,
                       input logic [7:0] exp, input logic chk);
        int n;
        @(negedge clk);
        isp_cmd_valid = 1'b1;
        isp_cmd = op;
        isp_addr = a;
        isp_data = d;
        for (n = 0; n < 100 && isp_cmd_ready !== 1'b1; n++) @(negedge clk);
        @(negedge clk);
        isp_cmd_valid = 1'b0;
        for (n = 0; n < 600 && isp_rsp_valid !== 1'b1; n++) @(negedge clk);
        check(isp_rsp_valid, 1'b1);
        if (chk) check(isp_rsp_data, exp);
    endtask

    // eight key bytes of all ones; lock opens only with the eighth
    task automatic unlock(input logic on_link);
        int k;
        for (k = 0; k < 8; k++) begin
            if (on_link) link(OP_VERIFY, KEY_BASE + 16'(k), ERASED, RSP_PASS, 1'b1);
            else in_system_programming(OP_VERIFY, KEY_BASE + 16'(k), ERASED, RSP_PASS, 1'b1);
            if (k == 6) check(on_link ? prog_unlocked : isp_unlocked, 1'b0);
        end
        check(on_link ? prog_unlocked : isp_unlocked, 1'b1);
    endtask

    initial begin
        arst_n = 1'b0;
        programmer_mode = 1'b1;
        i2c_clock_pad_one = 1'b1;
        i2c_clock_pad_two = 1'b1;
        isp_request = 1'b0;
        host_mode_request = 1'b0;
        isp_cmd_valid = 1'b0;
        isp_cmd = 8'h00;
        isp_addr = 16'h0000;
        isp_data = 8'h00;
        do_reset();
        repeat (6) @(negedge clk);
        for (i = 4; i <= 8; i++) link(8'(i), 16'h0000, 8'h00, RSP_REJECT, 1'b1);
        $display("locked commands done");
        link(OP_ERASE_ALL, 16'h0000, 8'h00, RSP_PASS, 1'b1);
        link(OP_VERIFY, KEY_BASE, 8'h00, RSP_FAIL, 1'b1);
        check(16'(bcnt), 16'(VERIFY_CYC));
        unlock(1'b1);
        link(OP_WR_INFO, 16'h0040, 8'hc7, RSP_PASS, 1'b1);
        link(OP_WR_INFO, 16'h0030, 8'h00, RSP_PASS, 1'b1);
        link(OP_WR_INFO, 16'h0039, 8'h00, RSP_PASS, 1'b1);
        link(OP_WR_INFO, 16'h0041, 8'h5a, RSP_PASS, 1'b1);
        link(OP_WR_INFO, 16'h0041, 8'h00, RSP_REJECT, 1'b1);
        link(OP_RD_INFO, 16'h0041, 8'h00, 8'h5a, 1'b1);
        link(OP_RD_INFO, 16'h0040, 8'h00, 8'hc7, 1'b1);
        link(OP_WR_MAIN, 16'h1234, 8'ha5, RSP_PASS, 1'b1);
        link(OP_FAST_WR, 16'h0000, 8'h3c, RSP_PASS, 1'b1);
        $display("programmer session done");
        // a request during the scan makes the boot code wait
        isp_request = 1'b1;
        for (r = 0; r < 4; r++) begin
            i2c_clock_pad_one = rows[r].p1;
            i2c_clock_pad_two = rows[r].p2;
            do_reset();
            repeat (12) @(negedge clk);
            check(wait_sec, rows[r].w);
            check(cal_checksum_ok, 1'b1);
            repeat (10 + SEC * rows[r].w) @(negedge clk);
            check({boot_active, user_code_run}, 2'b10);
            repeat (8) @(negedge clk);
            check({boot_active, user_code_run}, 2'b01);
            $display("boot row %0d done", r);
        end
        programmer_mode = 1'b0;
        i2c_clock_pad_one = 1'b1;
        i2c_clock_pad_two = 1'b1;
        isp_request = 1'b1;
        do_reset();
        repeat (15) @(negedge clk);
        isp_request = 1'b0;
        repeat (15) @(negedge clk);
        host_mode_request = 1'b1;
        repeat (2) @(negedge clk);
        host_mode_request = 1'b0;
        repeat (4) @(negedge clk);
        check({isp_active, user_code_run}, 2'b10);
        in_system_programming(OP_WR_MAIN, 16'h0000, 8'h00, RSP_REJECT, 1'b1);
        unlock(1'b0);
        in_system_programming(OP_SET_ADDR, 16'h1234, 8'h00, RSP_PASS, 1'b1);
        in_system_programming(OP_FAST_RD, 16'h0000, 8'h00, 8'ha5, 1'b1);
        in_system_programming(OP_FAST_RD, 16'h0000, 8'h00, 8'h3c, 1'b1);
        in_system_programming(OP_WR_INFO, 16'h0020, 8'h00, RSP_REJECT, 1'b1);
        in_system_programming(OP_RD_INFO, 16'h0020, 8'h00, ERASED, 1'b1);
        in_system_programming(OP_UNLOCK, 16'h0000, 8'h00, RSP_PASS, 1'b1);
        in_system_programming(OP_ERASE_SECTOR, 16'h1200, 8'h00, RSP_PASS, 1'b1);
        in_system_programming(OP_SET_ADDR, 16'h1234, 8'h00, RSP_PASS, 1'b1);
        in_system_programming(OP_FAST_RD, 16'h0000, 8'h00, ERASED, 1'b1);
        check(user_code_run, 1'b0);
        $display("isp session done");
        conclude();
    end
endmodule
